/* src/fetch_pc_cfg.svh */
/*
 * constants for the fetch sequencer and program counter: widths,
 * register offsets, reset values and timing counts.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef FETCH_PC_CFG_SVH
`define FETCH_PC_CFG_SVH

`define PC_WIDTH 12
`define PC_LOW_WIDTH 8
`define PC_RESET_ADDR 12'h000
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3
`define REG_ADDR_WIDTH 4
`define REG_PCL_OFFSET 4'h0
`define REG_STATUS_OFFSET 4'h1
`define REG_PCH_OFFSET 4'h2
`define STATUS_FULL_BIT 0
`define STATUS_EMPTY_BIT 1
`define STATUS_DUMMY_BIT 2
`define PHASE_COUNT 4

`endif

/* src/fetch_pc_pkg.sv */
/*
 * types shared by the fetch sequencer and its phase generator.
 * assumes fetch_pc_cfg.svh on the include path.
 */
`include "fetch_pc_cfg.svh"

package fetch_pc_pkg;

    // one-hot phase bundle, exactly one high per core clock
    typedef struct packed {
        logic t4;
        logic t3;
        logic t2;
        logic t1;
    } phase_t;

    // what the decode/execute side asks of the counter for this cycle
    typedef enum logic [2:0] {
        CF_SEQ = 3'b000,
        CF_JUMP = 3'b001,
        CF_CALL = 3'b010,
        CF_IRQ = 3'b011,
        CF_RET = 3'b100,
        CF_INTERRUPT_RETURN_INSTR = 3'b101,
        CF_SKIP = 3'b110
    } ctrl_op_t;

    typedef struct packed {
        ctrl_op_t op;
        logic [`PC_WIDTH-1:0] target;
    } ctrl_req_t;

    // instruction-cycle kinds of the sequencer
    typedef enum logic [1:0] {
        CYC_EXEC = 2'b00,
        CYC_DUMMY = 2'b01
    } cyc_state_t;

endpackage

/* src/phase_gen.sv */
/*
 * four-phase non-overlapping phase generator for one instruction cycle.
 * assumes a single core clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps

module phase_gen
    import fetch_pc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    output fetch_pc_pkg::phase_t o_phase
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    phase_t phase_d;
    phase_t phase_q;

    // rotate through phases; reset parks on the last phase so t1 is first after release
    assign cnt_d = cnt_q + 2'h1;
    assign phase_d = phase_t'(4'h1 << cnt_d);

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            cnt_q <= 2'h3;
            phase_q <= phase_t'(4'h8);
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign o_phase = phase_q;

endmodule

/* src/fetch_pc.sv */
/*
 * instruction fetch sequencer and program counter with return stack.
 * assumes program memory answers within one phase and decode presents
 * its control request during t4 of the executing instruction cycle.
 */
// Function
// - four non-overlapping phases run in order and one pass is one instruction cycle.
// - the counter advances at the start of phase one and the fetch happens in that phase.
// - the next fetch overlaps execution so plain instructions complete one per cycle.
// - a counter-changing instruction takes two instruction cycles.
// - the counter increases by one after each instruction unless control is redirected.
// - jump, call, interrupt and reset load the target address instead of the increment.
// - a taken skip discards the fetched instruction and runs a dummy cycle.
// - the counter is twelve bits and only its low byte is a software read/write register.
// - writing the low byte jumps within the current 256-word page, high bits kept.
// - writing the low byte inserts one dummy cycle to prefetch the new address.
// - after reset the counter is zero and execution starts there.
// - call and interrupt push the counter; both returns pop it back.
`timescale 1ns/10ps

`include "fetch_pc_cfg.svh"

module fetch_pc
    import fetch_pc_pkg::*;
#(
    parameter int PC_W = `PC_WIDTH,
    parameter int DEPTH = `STACK_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire fetch_pc_pkg::ctrl_req_t i_ctrl,
    input wire logic [15:0] i_instr,
    input wire logic [`REG_ADDR_WIDTH-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic [PC_W-1:0] o_fetch_addr,
    output logic o_fetch_en,
    output logic [15:0] o_exec_instr,
    output logic o_exec_valid,
    output fetch_pc_pkg::phase_t o_phase
);

    localparam int SP_W = $clog2(DEPTH);

    phase_t phase;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] stack_mem [DEPTH];
    logic [SP_W:0] sp_q;
    logic [SP_W:0] sp_d;
    cyc_state_t cyc_q;
    cyc_state_t cyc_d;
    logic [15:0] fetched_q;
    logic [15:0] exec_q;
    logic exec_valid_q;
    logic fetch_en_q;
    logic [7:0] rdata_q;
    logic pcl_wr_pend_q;
    logic [7:0] pcl_wr_val_q;
    logic boot_q;

    phase_gen u_phase (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .o_phase(phase)
    );

    // stack bookkeeping; a push on a full stack overwrites the newest entry
    function automatic logic [SP_W-1:0] slot(input logic [SP_W:0] sp);
        slot = sp[SP_W-1:0];
    endfunction

    wire end_of_cycle = phase.t4;
    wire is_call = (i_ctrl.op == CF_CALL) || (i_ctrl.op == CF_IRQ);
    wire is_ret = (i_ctrl.op == CF_RET) || (i_ctrl.op == CF_INTERRUPT_RETURN_INSTR);
    wire is_jump = (i_ctrl.op == CF_JUMP);
    wire is_skip = (i_ctrl.op == CF_SKIP);
    wire stack_empty = (sp_q == '0);
    wire stack_full = (sp_q == (SP_W+1)'(DEPTH));
    wire exec_cycle = (cyc_q == CYC_EXEC);
    wire branch_now = exec_cycle && (is_jump || is_call || is_ret);
    wire [PC_W-1:0] pc_inc = pc_q + PC_W'(1);
    wire [PC_W-1:0] stack_top = stack_mem[slot(sp_q - (SP_W+1)'(1))];
    wire [PC_W-1:0] page_target = {pc_q[PC_W-1:8], pcl_wr_val_q};

    // software access decode
    wire wr_pcl = i_reg_wr && (i_reg_addr == `REG_PCL_OFFSET);
    wire [7:0] status_word = {5'h00, exec_cycle ? 1'b0 : 1'b1, stack_empty, stack_full};
    wire [7:0] rd_mux;
    assign rd_mux = (i_reg_addr == `REG_PCL_OFFSET) ? pc_q[7:0] :
                    (i_reg_addr == `REG_STATUS_OFFSET) ? status_word :
                    (i_reg_addr == `REG_PCH_OFFSET) ? 8'(pc_q[PC_W-1:8]) :
                    8'h00;

    // next program counter, chosen once per instruction cycle at the t4/t1 boundary
    always_comb begin
        pc_d = pc_q;
        cyc_d = cyc_q;
        sp_d = sp_q;
        if (end_of_cycle) begin
            cyc_d = CYC_EXEC;
            pc_d = boot_q ? pc_q : pc_inc;
            if (boot_q) begin
                cyc_d = CYC_EXEC;
            end else if (pcl_wr_pend_q) begin
                pc_d = page_target;
                cyc_d = CYC_DUMMY;
            end else if (exec_cycle && is_skip) begin
                cyc_d = CYC_DUMMY;
            end else if (branch_now) begin
                cyc_d = CYC_DUMMY;
                if (is_ret && !stack_empty) begin
                    pc_d = stack_top;
                    sp_d = sp_q - (SP_W+1)'(1);
                end else if (is_call) begin
                    pc_d = i_ctrl.target;
                    sp_d = stack_full ? sp_q : sp_q + (SP_W+1)'(1);
                end else if (is_jump) begin
                    pc_d = i_ctrl.target;
                end
            end
        end
    end

    // program counter, cycle state and stack pointer
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pc_q <= PC_W'(`PC_RESET_ADDR);
            cyc_q <= CYC_EXEC;
            sp_q <= '0;
        end else begin
            pc_q <= pc_d;
            cyc_q <= cyc_d;
            sp_q <= sp_d;
        end
    end

    // stack storage; on overflow the newest slot is overwritten
    // the counter already points past the call, so it is the return address
    always_ff @(posedge i_core_clk) begin
        if (end_of_cycle && branch_now && is_call && !pcl_wr_pend_q && !boot_q) begin
            stack_mem[slot(stack_full ? sp_q - (SP_W+1)'(1) : sp_q)] <= pc_q;
        end
    end

    // software write to the low byte is held until the cycle boundary
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pcl_wr_pend_q <= 1'b0;
            pcl_wr_val_q <= 8'h00;
        end else if (wr_pcl) begin
            pcl_wr_pend_q <= 1'b1;
            pcl_wr_val_q <= i_reg_wdata;
        end else if (end_of_cycle) begin
            pcl_wr_pend_q <= 1'b0;
        end
    end

    // first boundary after reset keeps the counter, so the reset address is fetched first
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            boot_q <= 1'b1;
        end else if (end_of_cycle) begin
            boot_q <= 1'b0;
        end
    end

    // fetch in t1 overlapping execution of the previous word
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            fetch_en_q <= 1'b0;
            fetched_q <= 16'h0000;
        end else begin
            fetch_en_q <= end_of_cycle;
            if (phase.t1) begin
                fetched_q <= i_instr;
            end
        end
    end

    // execute stage: a dummy cycle presents no valid instruction
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            exec_q <= 16'h0000;
            exec_valid_q <= 1'b0;
        end else if (end_of_cycle) begin
            exec_q <= fetched_q;
            exec_valid_q <= !boot_q && (cyc_d == CYC_EXEC) && (cyc_q == CYC_EXEC || !pcl_wr_pend_q);
        end
    end

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_fetch_addr = pc_q;
    assign o_fetch_en = fetch_en_q;
    assign o_exec_instr = exec_q;
    assign o_exec_valid = exec_valid_q;
    assign o_phase = phase;

endmodule

/* verif/fetch_pc_properties.sv */
/* assertions on the fetch_pc ports.
   assumes one clock domain; bound in below. */
`timescale 1ns/10ps
`include "fetch_pc_cfg.svh"
module fetch_pc_properties
    import fetch_pc_pkg::*;
#(
    parameter int PC_W = `PC_WIDTH,
    parameter int DEPTH = `STACK_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire ctrl_req_t i_ctrl,
    input wire logic [15:0] i_instr,
    input wire logic [`REG_ADDR_WIDTH-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [PC_W-1:0] o_fetch_addr,
    input wire logic o_fetch_en,
    input wire logic [15:0] o_exec_instr,
    input wire logic o_exec_valid,
    input wire phase_t o_phase
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    logic pend_q;
    logic amb_q;
    logic [7:0] pcl_q;
    wire wr_pcl = i_reg_wr && i_reg_addr == `REG_PCL_OFFSET;
    wire tk = o_phase.t4 && !(pend_q || amb_q || wr_pcl);
    // pending low-byte write; one landing in t4 is left unchecked, its boundary is unclear
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pend_q <= 1'h0;
            amb_q <= 1'h0;
        end else if (wr_pcl) begin
            pend_q <= !o_phase.t4;
            amb_q <= o_phase.t4;
            pcl_q <= i_reg_wdata;
        end else if (o_phase.t4) begin
            pend_q <= 1'h0;
            amb_q <= 1'h0;
        end
    end
    // phases and fetch timing
    AST_ONEHOT: assert property ($onehot(o_phase)) else $error("phase not one-hot");
    AST_ROTATE: assert property (o_phase.t1 |=> o_phase.t2 ##1 o_phase.t3 ##1 o_phase.t4 ##1 o_phase.t1)
        else $error("phase order broken");
    AST_PC_HOLD: assert property (!o_phase.t1 |-> $stable(o_fetch_addr)) else $error("pc moved off t1");
    AST_FETCH_T1: assert property (o_fetch_en == o_phase.t1) else $error("fetch outside t1");
    AST_PIPE: assert property (o_fetch_en |-> ##4 (!o_exec_valid || o_exec_instr == $past(i_instr, 4)))
        else $error("executed word is not the fetched one");
    // counter updates at the t4 boundary
    AST_INC: assert property (tk && !$rose(i_nrst) && (i_ctrl.op inside {CF_SEQ, CF_SKIP} || !o_exec_valid) |=>
        o_fetch_addr == $past(o_fetch_addr) + 1'h1) else $error("pc did not step by one");
    AST_LOAD: assert property (tk && o_exec_valid && i_ctrl.op inside {CF_JUMP, CF_CALL, CF_IRQ} |=>
        o_fetch_addr == $past(i_ctrl.target)) else $error("pc not loaded with target");
    AST_DUMMY: assert property (tk && o_exec_valid && i_ctrl.op inside {CF_JUMP, CF_CALL, CF_IRQ, CF_SKIP} |=>
        !o_exec_valid [*4]) else $error("no dummy cycle after branch");
    AST_PCL_JUMP: assert property (o_phase.t4 && pend_q && !amb_q |=> !o_exec_valid &&
        o_fetch_addr == {$past(o_fetch_addr[PC_W-1:8]), $past(pcl_q)}) else $error("low byte jump wrong");
    AST_RD_PCL: assert property (i_reg_rd && i_reg_addr == `REG_PCL_OFFSET |=>
        o_reg_rdata == $past(o_fetch_addr[7:0])) else $error("low byte read wrong");
    AST_RST: assert property ($rose(i_nrst) |-> o_fetch_addr == `PC_RESET_ADDR && o_phase.t4 ##1
        o_phase.t1 && o_fetch_en && o_fetch_addr == `PC_RESET_ADDR)
        else $error("bad start after reset");
endmodule

bind fetch_pc fetch_pc_properties #(.PC_W(PC_W), .DEPTH(DEPTH)) u_props (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_ctrl(i_ctrl), .i_instr(i_instr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_fetch_addr(o_fetch_addr),
    .o_fetch_en(o_fetch_en), .o_exec_instr(o_exec_instr), .o_exec_valid(o_exec_valid), .o_phase(o_phase));

/* verif/prog_mem_model.sv */
/* program memory model for the fetch sequencer.
   assumes the fetch enable marks the fetch phase. */
`timescale 1ns/10ps
module prog_mem_model (
    input wire logic [11:0] i_addr,
    input wire logic i_en,
    output logic [15:0] o_word
);
    // word tags its address; idle bus shows the inverse so stale data never matches
    assign o_word = i_en ? {4'hC, i_addr} : ~{4'hC, i_addr};
endmodule

/* verif/fetch_pc_tb.sv */
/* self-checking bench for fetch_pc with a program memory model.
   assumes control requests are only made in t4. */
`timescale 1ns/10ps
`include "fetch_pc_cfg.svh"
module fetch_pc_tb
    import fetch_pc_pkg::*;
;
    typedef struct packed {
        ctrl_op_t op;
        logic [11:0] tgt;
        logic vld;
    } row_t;
    logic i_core_clk = 1'h0;
    logic i_nrst = 1'h0;
    ctrl_req_t i_ctrl = '0;
    logic [15:0] i_instr;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'h0;
    logic i_reg_rd = 1'h0;
    logic [7:0] o_reg_rdata;
    logic [11:0] o_fetch_addr;
    logic o_fetch_en;
    logic [15:0] o_exec_instr;
    logic o_exec_valid;
    phase_t o_phase;
    int fail_count = 0;
    int num_checks = 0;
    logic [11:0] stk[$];
    logic [11:0] pc_old;
    logic [11:0] exp_pc;
    // every control code at least once, nested call and interrupt
    row_t rows[8] = '{'{CF_SEQ, 12'h000, 1'h1}, '{CF_CALL, 12'h3F0, 1'h0}, '{CF_SEQ, 12'h000, 1'h1},
        '{CF_IRQ, 12'h004, 1'h0}, '{CF_INTERRUPT_RETURN_INSTR, 12'h000, 1'h0}, '{CF_RET, 12'h000, 1'h0},
        '{CF_JUMP, 12'h5A3, 1'h0}, '{CF_SKIP, 12'h000, 1'h0}};
    fetch_pc u_fetch_pc (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ctrl(i_ctrl), .i_instr(i_instr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_fetch_addr(o_fetch_addr), .o_fetch_en(o_fetch_en),
        .o_exec_instr(o_exec_instr), .o_exec_valid(o_exec_valid), .o_phase(o_phase));
    prog_mem_model u_prog_mem_model (.i_addr(o_fetch_addr), .i_en(o_fetch_en), .o_word(i_instr));
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        i_nrst <= 1'h0;
        repeat (12) @(posedge i_core_clk);
        #1 chk("pc in reset", 16'h0, o_fetch_addr);
        chk("phase in reset", 16'h8, o_phase);
        @(posedge i_core_clk);
        i_nrst <= 1'h1;
        @(posedge i_core_clk);
        #1 chk("phase after reset", 16'h1, o_phase);
        chk("pc after reset", 16'h0, o_fetch_addr);
        stk.delete();
    endtask
    // mode 1: request lands in a dummy cycle; mode 2: low-byte write pending
    task automatic issue(input ctrl_op_t op, input logic [11:0] tgt, input logic vld, input int mode);
        do @(posedge i_core_clk); while (o_phase !== 4'h4);
        pc_old = o_fetch_addr;
        i_ctrl <= '{op, tgt};
        @(posedge i_core_clk);
        i_ctrl <= '{CF_SEQ, 12'h000};
        exp_pc = pc_old + 12'h1;
        if (mode == 2) begin
            exp_pc = {pc_old[11:8], i_reg_wdata};
        end else if (mode == 0 && op inside {CF_JUMP, CF_CALL, CF_IRQ}) begin
            exp_pc = tgt;
        end else if (mode == 0 && op inside {CF_RET, CF_INTERRUPT_RETURN_INSTR}) begin
            exp_pc = stk.pop_back();
        end
        if (mode == 0 && op inside {CF_CALL, CF_IRQ}) begin
            stk.push_back(pc_old);
        end
        #1 chk("pc", exp_pc, o_fetch_addr);
        chk("exec valid", vld, o_exec_valid);
        if (vld) begin
            chk("exec instr", {4'hC, pc_old}, o_exec_instr);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'h1;
        @(posedge i_core_clk);
        i_reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'h1;
        @(posedge i_core_clk);
        i_reg_rd <= 1'h0;
        #1 chk("read data", exp, o_reg_rdata);
    endtask
    initial begin
        do_reset();
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].tgt, rows[i].vld, 0);
            repeat (4) @(posedge i_core_clk);
        end
        issue(CF_JUMP, 12'h123, 1'h0, 0);
        issue(CF_JUMP, 12'h777, 1'h1, 1);
        wr(`REG_PCL_OFFSET, 8'h3C);
        issue(CF_JUMP, 12'hABC, 1'h0, 2);
        rd(`REG_STATUS_OFFSET, (8'h01 << `STATUS_DUMMY_BIT) | (8'h01 << `STATUS_EMPTY_BIT));
        rd(`REG_PCL_OFFSET, exp_pc[7:0]);
        rd(`REG_PCH_OFFSET, {4'h0, exp_pc[11:8]});
        rd(4'hF, 8'h00);
        issue(CF_SEQ, 12'h000, 1'h1, 0);
        do_reset();
        print_verdict();
    end
    // a stalled phase would hang the run; the tests need about 120 cycles
    initial begin
        repeat (2000) @(posedge i_core_clk);
        fail_count++;
        print_verdict();
    end
endmodule
